/* File: core/dic_top.sv */
// Behaviour
// - two independent controllers A and B; each source steerable to either
// - registers are never byte-swapped; software uses big-endian access
// - pending bit sets only on inactive-to-active line transition
// - mask bit 1 enables pending source, 0 blocks; mask zero after reset
// - steering register cleared at reset, all sources start on A
// - new request bit makes the controller master one host-bus write
// - cycle after reading a request register, it and its pending bits clear
// - level register read-only, shows each implemented line active high
// - 32-bit word access; unimplemented bits ignore writes
// - address register holds target address and group code per controller
// - write address low five bits zero; data holds group code only
// - sources 0-5 pci, 6 external, 7 bus error, 8 keyboard, 10 serial
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.svh"

module dic_top (
	input wire logic clk_sys, // 10 MHz system clock
	input wire logic rst, // async reset, active high
	input wire logic [`DIC_NSRC-1:0] irq_line, // interrupt source pins, native sense
	input wire logic [`DIC_AW-1:0] avs_address, // register byte address
	input wire logic avs_read, // register read request
	input wire logic avs_write, // register write request
	input wire logic [31:0] avs_writedata, // register write data
	input wire logic [3:0] avs_byteenable, // write byte lanes
	output logic [31:0] avs_readdata, // register read data
	output logic avs_waitrequest, // low for the one accepting cycle
	output logic hb_write, // host-bus interrupt write request
	output logic [31:0] hb_address, // interrupt write address
	output logic [31:0] hb_writedata, // interrupt write data
	input wire logic hb_waitrequest, // host bus stall
	output logic irq // level interrupt, unmasked event pending
);
	import dic_pkg::*;

	dic_state_t st;
	dic_state_t next_st;
	logic [`DIC_NSRC-1:0] lvl;
	logic [`DIC_NSRC-1:0] rise;
	logic acc;
	logic rd;
	logic wr;
	logic [31:0] wmask;
	logic [`DIC_NSRC-1:0] impl;
	logic [`DIC_NSRC-1:0] new_a;
	logic [`DIC_NSRC-1:0] new_b;
	logic [`DIC_NEV-1:0] ev;
	logic [31:0] merged_mask;
	logic [31:0] merged_steer;

	dic_line_sync u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.line_raw(irq_line),
		.level(lvl),
		.rise(rise)
	);

	assign impl = `DIC_IMPL_MASK;
	// request seen while waitrequest is high: read data loaded then; a write lands at the edge that ends it
	assign acc = st.avs_wait & (avs_read | avs_write);
	assign rd = acc & avs_read;
	assign wr = ~st.avs_wait & avs_write;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	assign merged_mask = merge({21'h0, st.mask}, avs_writedata, wmask);
	assign merged_steer = merge({21'h0, st.steer}, avs_writedata, wmask);

	always_comb begin
		next_st = st;
		new_a = '0;
		new_b = '0;
		ev = '0;
		next_st.avs_wait = 1'b1;
		next_st.clr_a = 1'b0;
		next_st.clr_b = 1'b0;
		if (acc) begin
			next_st.avs_wait = 1'b0;
		end

		// read access; no byte swapping on the way out
		if (rd) begin
			case (avs_address)
				`DIC_OFS_TGT_A: next_st.avs_rdata = st.tgt_a;
				`DIC_OFS_TGT_B: next_st.avs_rdata = st.tgt_b;
				`DIC_OFS_REQ_A: begin
					next_st.avs_rdata = {21'h0, st.req_a};
					next_st.clr_a = 1'b1;
					next_st.clr_bits = st.req_a;
				end
				`DIC_OFS_REQ_B: begin
					next_st.avs_rdata = {21'h0, st.req_b};
					next_st.clr_b = 1'b1;
					next_st.clr_bits = st.req_b;
				end
				`DIC_OFS_MASK: next_st.avs_rdata = {21'h0, st.mask};
				`DIC_OFS_PEND: next_st.avs_rdata = {21'h0, st.pend};
				`DIC_OFS_STEER: next_st.avs_rdata = {21'h0, st.steer};
				`DIC_OFS_LEVEL: next_st.avs_rdata = {21'h0, lvl & impl};
				`DIC_OFS_IST: next_st.avs_rdata = {30'h0, st.ist};
				`DIC_OFS_IMASK: next_st.avs_rdata = {30'h0, st.imask};
				default: next_st.avs_rdata = 32'h0000_0000;
			endcase
		end

		// pending latch: edge-set, wins over any clear in the same cycle
		if (wr && avs_address == `DIC_OFS_PEND) begin
			next_st.pend = '0;
		end else if (st.clr_a || st.clr_b) begin
			next_st.pend = st.pend & ~st.clr_bits;
		end
		next_st.pend = next_st.pend | (rise & impl);

		// register writes, unimplemented bits untouched
		if (wr) begin
			case (avs_address)
				`DIC_OFS_TGT_A: next_st.tgt_a = merge(st.tgt_a, avs_writedata, wmask);
				`DIC_OFS_TGT_B: next_st.tgt_b = merge(st.tgt_b, avs_writedata, wmask);
				`DIC_OFS_MASK: next_st.mask = merged_mask[`DIC_NSRC-1:0] & impl;
				`DIC_OFS_STEER: next_st.steer = merged_steer[`DIC_NSRC-1:0] & impl;
				`DIC_OFS_IST: next_st.ist = st.ist & ~(avs_writedata[`DIC_NEV-1:0] & wmask[`DIC_NEV-1:0]);
				`DIC_OFS_IMASK: next_st.imask = avs_writedata[`DIC_NEV-1:0];
				default: next_st.avs_wait = 1'b1; // unmapped: acknowledged, ignored
			endcase
		end

		// request registers follow pending, mask and steering
		next_st.req_a = st.clr_a ? '0 : st.pend & st.mask & ~st.steer;
		next_st.req_b = st.clr_b ? '0 : st.pend & st.mask & st.steer;
		new_a = next_st.req_a & ~st.req_a;
		new_b = next_st.req_b & ~st.req_b;
		if (|new_a) begin
			next_st.wr_pend_a = 1'b1;
		end
		if (|new_b) begin
			next_st.wr_pend_b = 1'b1;
		end

		// host-bus write engine, A before B
		case (st.hb_st)
			DIC_HB_IDLE: begin
				if (st.wr_pend_a) begin
					next_st.wr_pend_a = |new_a;
					next_st.hb_st = DIC_HB_WRITE;
					next_st.hb_write = 1'b1;
					next_st.hb_src_b = 1'b0;
					next_st.hb_address = st.tgt_a & `DIC_ADDR_LOW_ZERO;
					next_st.hb_writedata = st.tgt_a & `DIC_GROUP_BITS;
				end else if (st.wr_pend_b) begin
					next_st.wr_pend_b = |new_b;
					next_st.hb_st = DIC_HB_WRITE;
					next_st.hb_write = 1'b1;
					next_st.hb_src_b = 1'b1;
					next_st.hb_address = st.tgt_b & `DIC_ADDR_LOW_ZERO;
					next_st.hb_writedata = st.tgt_b & `DIC_GROUP_BITS;
				end
			end
			DIC_HB_WRITE: begin
				if (!hb_waitrequest) begin
					next_st.hb_st = DIC_HB_IDLE;
					next_st.hb_write = 1'b0;
					ev[st.hb_src_b] = 1'b1;
				end
			end
			default: begin
				next_st.hb_st = DIC_HB_IDLE;
				next_st.hb_write = 1'b0;
			end
		endcase

		// completed interrupt writes are sticky; set beats a same-cycle clear
		next_st.ist = next_st.ist | ev;
		next_st.irq = |(next_st.ist & next_st.imask);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= '0; // mask and steering zero: all blocked, all on A
			st.avs_wait <= 1'b1;
			st.hb_st <= DIC_HB_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata = st.avs_rdata;
	assign avs_waitrequest = st.avs_wait;
	assign hb_write = st.hb_write;
	assign hb_address = st.hb_address;
	assign hb_writedata = st.hb_writedata;
	assign irq = st.irq;

	// checks
	logic [`DIC_NSRC-1:0] rise_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rise_q <= '0;
		end else begin
			rise_q <= rise;
		end
	end

	default clocking dic_cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_pend_on_rise: assert property (rise[0] |=> st.pend[0])
		else $error("pending bit not set on rising line");
	a_pend_no_spur: assert property (!rise[0] && !st.pend[0] |=> !st.pend[0])
		else $error("pending bit set without transition");
	a_pend_wclear: assert property (wr && avs_address == `DIC_OFS_PEND |=> (st.pend & ~rise_q) == '0)
		else $error("pending write did not clear register");
	a_mask_blocks: assert property (st.mask == '0 |=> st.req_a == '0 && st.req_b == '0)
		else $error("request raised while masked");
	a_steer_route_a: assert property (st.pend[0] && st.mask[0] && !st.steer[0] && !st.clr_a
		|=> st.req_a[0] && !st.req_b[0])
		else $error("source not routed to controller A");
	a_read_clear: assert property (rd && avs_address == `DIC_OFS_REQ_A |-> ##2 st.req_a == '0)
		else $error("request A not cleared after read");
	a_write_hold: assert property (hb_write && hb_waitrequest |=> hb_write && $stable(hb_address)
		&& $stable(hb_writedata))
		else $error("interrupt write dropped while stalled");
	a_write_format: assert property (hb_write |-> hb_address[4:0] == 5'h00 && hb_writedata[31:5] == 27'h0)
		else $error("interrupt write format wrong");
	a_a_first: assert property (st.hb_st == DIC_HB_IDLE && st.wr_pend_a && st.wr_pend_b
		|=> hb_write && !st.hb_src_b ##1 (st.wr_pend_b || st.hb_src_b))
		else $error("controller B served before A or lost");
	a_new_req_write: assert property ($rose(st.req_a[0]) |-> ##[0:3] (st.wr_pend_a || hb_write))
		else $error("new request raised no write");

	c_both_wait: cover property (st.wr_pend_a && st.wr_pend_b);
	c_write_done: cover property (hb_write && !hb_waitrequest);
	c_read_clear: cover property (rd && avs_address == `DIC_OFS_REQ_B && st.req_b != '0);
	c_irq: cover property ($rose(irq));

	// per-source checks on latching and routing
	logic [`DIC_NSRC-1:0] want_a;
	logic [`DIC_NSRC-1:0] want_b;

	assign want_a = st.pend & st.mask & ~st.steer;
	assign want_b = st.pend & st.mask & st.steer;

	genvar gi;
	generate
		for (gi = 0; gi < `DIC_NSRC; gi++) begin : g_chk
			a_pend_bit: assert property (rise[gi] && impl[gi] |=> st.pend[gi])
				else $error("pending bit missed a transition");
			a_quiet_bit: assert property (!rise[gi] && !st.pend[gi] |=> !st.pend[gi])
				else $error("pending bit set with no transition");
			a_route_bit: assert property (st.pend[gi] && st.mask[gi] && !st.clr_a && !st.clr_b
				|=> st.req_a[gi] != $past(st.steer[gi]) && st.req_b[gi] == $past(st.steer[gi]))
				else $error("source routed to wrong controller");
		end
	endgenerate

	// register bus
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_level_view: assert property (rd && avs_address == `DIC_OFS_LEVEL
		|=> avs_readdata[`DIC_NSRC-1:0] == ($past(lvl) & impl))
		else $error("level register read wrong");

	a_unimpl_quiet: assert property (((st.mask | st.steer | st.pend) & ~impl) == '0)
		else $error("unimplemented bit became set");

	// request registers
	a_req_a_form: assert property (!st.clr_a |=> st.req_a == $past(want_a))
		else $error("request A does not follow pending and mask");

	a_req_b_form: assert property (!st.clr_b |=> st.req_b == $past(want_b))
		else $error("request B does not follow pending and mask");

	a_read_clear_b: assert property (rd && avs_address == `DIC_OFS_REQ_B |-> ##2 st.req_b == '0)
		else $error("request B not cleared after read");

	a_pend_rd_clr: assert property (st.clr_a || st.clr_b |=> (st.pend & $past(st.clr_bits) & ~rise_q) == '0)
		else $error("pending bits survived a request read");

	// write engine
	a_hb_quiet: assert property (st.hb_st == DIC_HB_IDLE |-> !hb_write)
		else $error("interrupt write raised while idle");

	a_one_at_time: assert property (hb_write && !hb_waitrequest |=> !hb_write)
		else $error("interrupt writes not separated");

	a_tgt_a_used: assert property ($rose(hb_write) && !st.hb_src_b
		|-> hb_address == ($past(st.tgt_a) & `DIC_ADDR_LOW_ZERO)
		&& hb_writedata == ($past(st.tgt_a) & `DIC_GROUP_BITS))
		else $error("controller A write not from its address register");

	a_tgt_b_used: assert property ($rose(hb_write) && st.hb_src_b
		|-> hb_address == ($past(st.tgt_b) & `DIC_ADDR_LOW_ZERO)
		&& hb_writedata == ($past(st.tgt_b) & `DIC_GROUP_BITS))
		else $error("controller B write not from its address register");

	// status and interrupt
	a_ist_sticky: assert property (!(wr && avs_address == `DIC_OFS_IST) |=> (st.ist & $past(st.ist)) == $past(st.ist))
		else $error("event status bit lost without a clear");

	a_irq_level: assert property (irq == |(st.ist & st.imask))
		else $error("interrupt output disagrees with status");

	c_write_b: cover property (hb_write && st.hb_src_b && !hb_waitrequest);
endmodule

`default_nettype wire

/* File: core/dic_consts.svh */
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

`define DIC_NSRC 11
`define DIC_AW 6
// implemented sources: 0..5 pci lines, 6 host ext, 7 bus error, 8 keyboard, 10 serial
`define DIC_IMPL_MASK 11'h5FF
// lines whose native sense is active low (pci lines)
`define DIC_LOW_TRUE 11'h03F
`define DIC_OFS_TGT_A 6'h04
`define DIC_OFS_REQ_A 6'h0C
`define DIC_OFS_TGT_B 6'h10
`define DIC_OFS_REQ_B 6'h14
`define DIC_OFS_MASK 6'h18
`define DIC_OFS_PEND 6'h1C
`define DIC_OFS_STEER 6'h24
`define DIC_OFS_LEVEL 6'h28
`define DIC_OFS_IST 6'h30
`define DIC_OFS_IMASK 6'h34
`define DIC_NEV 2
`define DIC_ADDR_LOW_ZERO 32'hFFFF_FFE0
`define DIC_GROUP_BITS 32'h0000_001F

`endif

/* File: core/dic_pkg.sv */
`include "dic_consts.svh"

package dic_pkg;
	typedef enum logic [1:0] {DIC_HB_IDLE, DIC_HB_WRITE} dic_hb_state_t;

	typedef struct packed {
		logic [`DIC_NSRC-1:0] s1;
		logic [`DIC_NSRC-1:0] s2;
		logic [`DIC_NSRC-1:0] s3;
	} dic_sync_t;

	typedef struct packed {
		logic [`DIC_NSRC-1:0] pend;
		logic [`DIC_NSRC-1:0] mask;
		logic [`DIC_NSRC-1:0] steer;
		logic [31:0] tgt_a;
		logic [31:0] tgt_b;
		logic [`DIC_NSRC-1:0] req_a;
		logic [`DIC_NSRC-1:0] req_b;
		logic clr_a;
		logic clr_b;
		logic [`DIC_NSRC-1:0] clr_bits;
		logic wr_pend_a;
		logic wr_pend_b;
		dic_hb_state_t hb_st;
		logic hb_write;
		logic [31:0] hb_address;
		logic [31:0] hb_writedata;
		logic hb_src_b;
		logic avs_wait;
		logic [31:0] avs_rdata;
		logic [`DIC_NEV-1:0] ist;
		logic [`DIC_NEV-1:0] imask;
		logic irq;
	} dic_state_t;
endpackage

/* File: core/dic_line_sync.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.svh"

module dic_line_sync (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [`DIC_NSRC-1:0] line_raw, // interrupt pins, native sense
	output logic [`DIC_NSRC-1:0] level, // synchronised, active high
	output logic [`DIC_NSRC-1:0] rise // one-cycle inactive-to-active pulse
);
	import dic_pkg::*;

	localparam logic [`DIC_NSRC-1:0] LOWT = `DIC_LOW_TRUE;

	dic_sync_t st;
	dic_sync_t next_st;

	// pins pass both flops untouched; polarity is fixed only after the second one
	genvar i;
	generate
		for (i = 0; i < `DIC_NSRC; i++) begin : g_line
			assign level[i] = st.s2[i] ^ LOWT[i];
			assign rise[i] = level[i] & ~st.s3[i];
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.s1 = line_raw;
		next_st.s2 = st.s1;
		next_st.s3 = level;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// flops start at the idle pin level so release shows no false edge
			st <= {LOWT, LOWT, {`DIC_NSRC{1'b0}}};
		end else begin
			st <= next_st;
		end
	end
endmodule

`default_nettype wire

/* File: bench/dic_host_sink.sv */
`timescale 1ns/1ps
`default_nettype none

module dic_host_sink (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, active high
	input wire logic [3:0] stall, // each write is stalled this many cycles plus one
	input wire logic hb_write, // interrupt write request
	input wire logic [31:0] hb_address, // interrupt write address
	input wire logic [31:0] hb_writedata, // interrupt write data
	output logic hb_waitrequest, // stall towards the block
	output logic [7:0] n_writes, // writes accepted
	output logic [63:0] prev_wr, // address and data, write before last
	output logic [63:0] last_wr // address and data, last write
);
	logic [3:0] cnt;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hb_waitrequest <= 1'b1;
			cnt <= 4'h0;
			n_writes <= 8'h00;
			prev_wr <= 64'h0;
			last_wr <= 64'h0;
		end else if (hb_write && !hb_waitrequest) begin
			// taken at this edge; stall again for the next write
			hb_waitrequest <= 1'b1;
			cnt <= 4'h0;
			n_writes <= n_writes + 8'h01;
			prev_wr <= last_wr;
			last_wr <= {hb_address, hb_writedata};
		end else if (hb_write) begin
			hb_waitrequest <= (cnt >= stall) ? 1'b0 : 1'b1;
			cnt <= cnt + 4'h1;
		end
	end
endmodule

`default_nettype wire

/* File: bench/dual_interrupt_controller_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dic_consts.svh"

module dual_interrupt_controller_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [10:0] irq_line = `DIC_LOW_TRUE;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, hb_address, hb_writedata, rd;
	logic avs_waitrequest, hb_write, hb_waitrequest, irq;
	logic [3:0] stall = 4'h3;
	logic [7:0] n_writes;
	logic [63:0] prev_wr, last_wr;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;

	always #50 clk_sys = ~clk_sys;

	dic_top i_dic_top (.clk_sys(clk_sys), .rst(rst), .irq_line(irq_line), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hb_write(hb_write),
		.hb_address(hb_address), .hb_writedata(hb_writedata), .hb_waitrequest(hb_waitrequest), .irq(irq));

	dic_host_sink i_dic_host_sink (.clk_sys(clk_sys), .rst(rst), .stall(stall), .hb_write(hb_write),
		.hb_address(hb_address), .hb_writedata(hb_writedata), .hb_waitrequest(hb_waitrequest),
		.n_writes(n_writes), .prev_wr(prev_wr), .last_wr(last_wr));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_mismatch = n_mismatch + 1;
			$display("Error watchdog expected done seen hung");
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus cycle; request held until waitrequest is seen low
	task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	// unimplemented bits read zero but are masked off, so only implemented ones compare
	task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0);
		check(what, exp, rd & {21'h0, `DIC_IMPL_MASK});
	endtask

	task automatic pulse_line0();
		irq_line <= irq_line ^ 11'h001;
		repeat (6) @(posedge clk_sys);
		irq_line <= irq_line ^ 11'h001;
		repeat (10) @(posedge clk_sys);
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd_chk("mask", `DIC_OFS_MASK, 32'h0);
		rd_chk("steer", `DIC_OFS_STEER, 32'h0);
		rd_chk("level idle", `DIC_OFS_LEVEL, 32'h0);
		access(1'b1, `DIC_OFS_TGT_A, 32'h1234_5677);
		access(1'b1, `DIC_OFS_TGT_B, 32'hABCD_E0E9);
		access(1'b1, `DIC_OFS_STEER, 32'h0000_0400);
		access(1'b1, `DIC_OFS_MASK, 32'hFFFF_FFFF);
		access(1'b0, `DIC_OFS_TGT_A, 32'h0);
		check("target a", 32'h1234_5677, rd);
		rd_chk("mask all", `DIC_OFS_MASK, 32'h0000_05FF);
		irq_line <= irq_line ^ 11'h401;
		while (n_writes !== 8'h02) @(posedge clk_sys);
		check("first addr", 32'h1234_5660, prev_wr[63:32]);
		check("first data", 32'h0000_0017, prev_wr[31:0]);
		check("second addr", 32'hABCD_E0E0, last_wr[63:32]);
		check("second data", 32'h0000_0009, last_wr[31:0]);
		rd_chk("level", `DIC_OFS_LEVEL, 32'h0000_0401);
		rd_chk("pending", `DIC_OFS_PEND, 32'h0000_0401);
		rd_chk("req a", `DIC_OFS_REQ_A, 32'h0000_0001);
		rd_chk("req a again", `DIC_OFS_REQ_A, 32'h0);
		rd_chk("pend after a", `DIC_OFS_PEND, 32'h0000_0400);
		rd_chk("req b", `DIC_OFS_REQ_B, 32'h0000_0400);
		repeat (10) @(posedge clk_sys);
		rd_chk("held lines", `DIC_OFS_PEND, 32'h0);
		access(1'b1, `DIC_OFS_REQ_A, 32'hFFFF_FFFF);
		rd_chk("req a ro", `DIC_OFS_REQ_A, 32'h0);
		access(1'b1, `DIC_OFS_MASK, 32'h0000_0400);
		pulse_line0();
		rd_chk("masked pend", `DIC_OFS_PEND, 32'h0000_0001);
		rd_chk("masked req a", `DIC_OFS_REQ_A, 32'h0);
		access(1'b1, `DIC_OFS_PEND, 32'h0000_0000);
		rd_chk("pend wiped", `DIC_OFS_PEND, 32'h0);
		check("writes", 32'h2, {24'h0, n_writes});
		stall <= 4'h0;
		access(1'b1, `DIC_OFS_MASK, 32'hFFFF_FFFF);
		pulse_line0();
		while (n_writes !== 8'h03) @(posedge clk_sys);
		check("prompt addr", 32'h1234_5660, last_wr[63:32]);
		rd_chk("status", `DIC_OFS_IST, 32'h3);
		check("irq masked", 32'h0, {31'h0, irq});
		access(1'b1, `DIC_OFS_IMASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		check("irq on", 32'h1, {31'h0, irq});
		access(1'b1, `DIC_OFS_IST, 32'h1);
		repeat (2) @(posedge clk_sys);
		check("irq cleared", 32'h0, {31'h0, irq});
		rd_chk("status b", `DIC_OFS_IST, 32'h2);
		rd_chk("unmapped", 6'h3C, 32'h0);
		end_of_test();
	end
endmodule

`default_nettype wire
